// >>> core/bph_pkg.sv
// Constants and shared types for the bidirectional port handshake controller
package bph_pkg;

    // ************************************************************
    // Bus and data widths
    // ************************************************************
    localparam int          APB_AW       = 12;
    localparam int          APB_DW       = 32;
    localparam int          PORT_W       = 8;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [3:0]  OFS_PORT_A   = 4'h0;
    localparam logic [3:0]  OFS_PORT_B   = 4'h4;
    localparam logic [3:0]  OFS_PORT_C   = 4'h8;
    localparam logic [3:0]  OFS_CTRL     = 4'hC;

    // ************************************************************
    // Control word fields
    // ************************************************************
    localparam int          CW_MODE_SET  = 7;
    localparam int          CW_A_MODE_HI = 6;
    localparam int          CW_A_MODE_LO = 5;
    localparam int          CW_PA_IN     = 4;
    localparam int          CW_PCU_IN    = 3;
    localparam int          CW_B_MODE    = 2;
    localparam int          CW_PB_IN     = 1;
    localparam int          CW_PCL_IN    = 0;
    localparam int          CW_BSR_VAL   = 0;
    localparam int          CW_BSR_SEL   = 1;
    localparam int          CW_BSR_SEL_W = 3;

    // ************************************************************
    // Control port line positions
    // ************************************************************
    localparam int          PC_IRQ_OUT_B    = 0;
    localparam int          PC_FULL_B    = 1;
    localparam int          PC_HS_B      = 2;
    localparam int          PC_IRQ_OUT_A    = 3;
    localparam int          PC_LOAD_A    = 4;
    localparam int          PC_IBF_A     = 5;
    localparam int          PC_ACK_A     = 6;
    localparam int          PC_OBF_A     = 7;

    // ************************************************************
    // Modes and flag force selectors
    // ************************************************************
    typedef enum logic [1:0] {
        BPH_MODE_BASIC   = 2'b00,
        BPH_MODE_STROBED = 2'b01,
        BPH_MODE_BIDIR   = 2'b10
    } bph_mode_t;

    typedef enum logic [1:0] {
        BPH_FRC_IRQ_OUT = 2'b00,
        BPH_FRC_IBF  = 2'b01,
        BPH_FRC_OBF  = 2'b10
    } bph_frc_t;

    // ************************************************************
    // Reset values: basic mode, every port an input
    // ************************************************************
    localparam bph_mode_t   RST_A_MODE   = BPH_MODE_BASIC;
    localparam logic        RST_B_MODE   = 1'b0;
    localparam logic        RST_DIR_IN   = 1'b1;
    localparam logic [7:0]  RST_PORT     = 8'h00;

endpackage

// >>> core/bph_hs_if.sv
// Signals between the port controller and one handshake group engine
`timescale 1ns/1ns
interface bph_hs_if;
    logic               en_in;
    logic               en_out;
    logic               clr;
    logic               stb_n;
    logic               ack_n;
    logic [7:0]         pins;
    logic               rd_start;
    logic               rd_done;
    logic               wr_start;
    logic               wr_done;
    logic               ie_in;
    logic               ie_out;
    logic               frc_we;
    bph_pkg::bph_frc_t  frc_sel;
    logic               frc_val;
    logic [7:0]         latch;
    logic               in_buf_full;
    logic               obf_n;
    logic               irq_out;
    logic               drive_en;

    modport ctl (
        output en_in, en_out, clr, stb_n, ack_n, pins, rd_start, rd_done,
        output wr_start, wr_done, ie_in, ie_out, frc_we, frc_sel, frc_val,
        input  latch, in_buf_full, obf_n, irq_out, drive_en
    );
    modport eng (
        input  en_in, en_out, clr, stb_n, ack_n, pins, rd_start, rd_done,
        input  wr_start, wr_done, ie_in, ie_out, frc_we, frc_sel, frc_val,
        output latch, in_buf_full, obf_n, irq_out, drive_en
    );
endinterface

// >>> core/bph_hs_group.sv
// Strobe and acknowledge handshake engine for one port group
`timescale 1ns/1ns
module bph_hs_group (
    // Clock and reset
    input  wire logic   mclk,
    input  wire logic   rst,
    // Controller side
    bph_hs_if.eng       hs
);
    typedef struct packed {
        logic [7:0] latch;
        logic       in_buf_full;
        logic       out_buf_full_n;
        logic       irq_out_in;
        logic       irq_out_out;
        logic       acked;
        logic       rd_pend;
    } bph_eng_st_t;

    bph_eng_st_t st_q;
    bph_eng_st_t st_d;

    always_comb begin
        st_d = st_q;
        // ************************************************************
        // Input direction
        // ************************************************************
        if (!hs.en_in) begin
            st_d.in_buf_full = 1'b0;
            st_d.irq_out_in = 1'b0;
            st_d.rd_pend = 1'b0;
        end else begin
            if (hs.rd_start) begin
                st_d.rd_pend = 1'b1;
                st_d.irq_out_in = 1'b0;
            end
            if (hs.rd_done) begin
                st_d.in_buf_full = 1'b0;
                st_d.rd_pend = 1'b0;
            end
            if (!hs.stb_n) begin
                st_d.latch = hs.pins;
                st_d.in_buf_full = 1'b1;
            end
            if (hs.stb_n && st_q.in_buf_full && hs.ie_in && !st_q.rd_pend && !hs.rd_start) begin
                st_d.irq_out_in = 1'b1;
            end
        end
        // ************************************************************
        // Output direction
        // ************************************************************
        if (!hs.en_out) begin
            st_d.out_buf_full_n = 1'b0;
            st_d.irq_out_out = 1'b0;
            st_d.acked = 1'b0;
        end else begin
            if (hs.wr_start) begin
                st_d.irq_out_out = 1'b0;
                st_d.acked = 1'b0;
            end
            if (!hs.ack_n) begin
                st_d.out_buf_full_n = 1'b0;
                if (st_q.out_buf_full_n) begin
                    st_d.acked = 1'b1;
                end
            end
            if (hs.wr_done) begin
                st_d.out_buf_full_n = 1'b1;
            end
            if (hs.ack_n && !st_q.out_buf_full_n && st_q.acked && hs.ie_out && !hs.wr_start) begin
                st_d.irq_out_out = 1'b1;
            end
        end
        // Software forcing of a handshake output line
        if (hs.frc_we) begin
            case (hs.frc_sel)
                bph_pkg::BPH_FRC_IRQ_OUT: begin
                    st_d.irq_out_in = 1'b0;
                    st_d.irq_out_out = hs.frc_val;
                    // Drop the pending acknowledge so the forced level holds
                    st_d.acked = 1'b0;
                end
                bph_pkg::BPH_FRC_IBF: begin
                    st_d.in_buf_full = hs.frc_val;
                end
                bph_pkg::BPH_FRC_OBF: begin
                    st_d.out_buf_full_n = !hs.frc_val;
                end
                default: begin
                    st_d.acked = st_q.acked;
                end
            endcase
        end
        if (hs.clr) begin
            st_d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign hs.latch = st_q.latch;
    assign hs.in_buf_full = st_q.in_buf_full;
    assign hs.obf_n = !st_q.out_buf_full_n;
    assign hs.irq_out = st_q.irq_out_in | st_q.irq_out_out;
    assign hs.drive_en = !hs.ack_n;

endmodule

// >>> core/bph_port_ctrl.sv
// Parallel port controller with strobed and bidirectional handshake modes
`timescale 1ns/1ns
// Operation
// - bidirectional mode raises irq_out for service
// - CPU write drives obf_n low
// - port A in bidirectional mode drives only while acknowledge low
// - out_irq_enable changed by bit-6 set/reset
// - periph_load_n low captures port A pins
// - in_buf_full high while byte unread
// - in_irq_enable changed by bit-4 set/reset
// - strobed input layout of control port
// - strobed output layout of control port
// - unclaimed control lines are plain I/O
// - control read shows pins, enables at 2/4/6
// - direct control write hits basic-mode outputs only
// - set/reset forces any output line
// - set/reset ignores plain input lines
// - set/reset on strobe/ack position sets enable
// - group A enables at positions 4 and 6
// - handshake modes use control port lines
// - status read is ordinary control read
// - output full set by write, cleared by ack
// - input full set by strobe, cleared after read
// - input interrupt set after strobe, cleared on read
// - mode set or reset clears flags and outputs
module bph_port_ctrl (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [bph_pkg::APB_AW-1:0]   paddr,
    input  wire logic [bph_pkg::APB_DW-1:0]   pwdata,
    output logic                              pready,
    output logic [bph_pkg::APB_DW-1:0]        prdata,
    output logic                              pslverr,
    // Data port A
    input  wire logic [7:0]                   pa_in,
    output logic [7:0]                        pa_out,
    output logic [7:0]                        pa_oe,
    // Data port B
    input  wire logic [7:0]                   pb_in,
    output logic [7:0]                        pb_out,
    output logic [7:0]                        pb_oe,
    // Control port C
    input  wire logic [7:0]                   pc_in,
    output logic [7:0]                        pc_out,
    output logic [7:0]                        pc_oe
);
    typedef struct packed {
        bph_pkg::bph_mode_t a_mode;
        logic               pa_in_dir;
        logic               pcu_in;
        logic               b_mode;
        logic               pb_in_dir;
        logic               pcl_in;
        logic               group_b_irq_enable;
        logic               group_a_in_irq_enable;
        logic               group_a_out_irq_enable;
        logic [7:0]         pa_q;
        logic [7:0]         pb_q;
        logic [7:0]         pc_q;
        logic [7:0]         rdata;
    } bph_top_st_t;

    localparam bph_top_st_t ST_RST = '{
        a_mode:                 bph_pkg::RST_A_MODE,
        pa_in_dir:              bph_pkg::RST_DIR_IN,
        pcu_in:                 bph_pkg::RST_DIR_IN,
        b_mode:                 bph_pkg::RST_B_MODE,
        pb_in_dir:              bph_pkg::RST_DIR_IN,
        pcl_in:                 bph_pkg::RST_DIR_IN,
        group_b_irq_enable:     1'b0,
        group_a_in_irq_enable:  1'b0,
        group_a_out_irq_enable: 1'b0,
        pa_q:                   bph_pkg::RST_PORT,
        pb_q:                   bph_pkg::RST_PORT,
        pc_q:                   bph_pkg::RST_PORT,
        rdata:                  bph_pkg::RST_PORT
    };

    bph_top_st_t st_q;
    bph_top_st_t st_d;

    bph_hs_if hs_a ();
    bph_hs_if hs_b ();

    // ************************************************************
    // APB decode
    // ************************************************************
    logic        setup;
    logic        access;
    logic        addr_ok;
    logic [3:0]  ofs;
    logic        sel_a;
    logic        sel_b;
    logic        mode_wr;
    logic        bsr_wr;
    logic [2:0]  bsr_bit;
    logic        bsr_val;

    assign setup = psel & !penable;
    assign access = psel & penable;
    assign ofs = paddr[3:0];
    assign addr_ok = (paddr[bph_pkg::APB_AW-1:4] == '0) && (paddr[1:0] == 2'h0);
    assign sel_a = addr_ok && (ofs == bph_pkg::OFS_PORT_A);
    assign sel_b = addr_ok && (ofs == bph_pkg::OFS_PORT_B);
    assign mode_wr = access && pwrite && addr_ok && (ofs == bph_pkg::OFS_CTRL)
                     && pwdata[bph_pkg::CW_MODE_SET];
    assign bsr_wr = access && pwrite && addr_ok && (ofs == bph_pkg::OFS_CTRL)
                    && !pwdata[bph_pkg::CW_MODE_SET];
    assign bsr_bit = pwdata[bph_pkg::CW_BSR_SEL +: bph_pkg::CW_BSR_SEL_W];
    assign bsr_val = pwdata[bph_pkg::CW_BSR_VAL];

    assign pready = 1'b1;
    assign pslverr = access & !addr_ok;
    assign prdata = {{(bph_pkg::APB_DW-8){1'b0}}, st_q.rdata};

    // ************************************************************
    // Group roles
    // ************************************************************
    logic a_hs;
    logic a_bidir;
    logic a_in_hs;
    logic a_out_hs;
    logic b_in_hs;
    logic b_out_hs;

    assign a_hs = (st_q.a_mode != bph_pkg::BPH_MODE_BASIC);
    assign a_bidir = (st_q.a_mode == bph_pkg::BPH_MODE_BIDIR);
    assign a_in_hs = a_bidir || (a_hs && st_q.pa_in_dir);
    assign a_out_hs = a_bidir || (a_hs && !st_q.pa_in_dir);
    assign b_in_hs = st_q.b_mode && st_q.pb_in_dir;
    assign b_out_hs = st_q.b_mode && !st_q.pb_in_dir;

    // ************************************************************
    // Control port line assignment
    // ************************************************************
    logic [7:0] hs_out;
    logic [7:0] hs_in;
    logic [7:0] hs_val;
    logic [7:0] io_out;
    logic [7:0] wr_mask;
    logic [7:0] ie_vec;
    logic [7:0] pc_rd;

    always_comb begin
        hs_out = 8'h00;
        hs_in = 8'h00;
        hs_val = 8'h00;
        hs_out[bph_pkg::PC_IRQ_OUT_B] = st_q.b_mode;
        hs_out[bph_pkg::PC_FULL_B] = st_q.b_mode;
        hs_in[bph_pkg::PC_HS_B] = st_q.b_mode;
        hs_out[bph_pkg::PC_IRQ_OUT_A] = a_hs;
        hs_in[bph_pkg::PC_LOAD_A] = a_in_hs;
        hs_out[bph_pkg::PC_IBF_A] = a_in_hs;
        hs_in[bph_pkg::PC_ACK_A] = a_out_hs;
        hs_out[bph_pkg::PC_OBF_A] = a_out_hs;
        hs_val[bph_pkg::PC_IRQ_OUT_B] = hs_b.irq_out;
        hs_val[bph_pkg::PC_FULL_B] = st_q.pb_in_dir ? hs_b.in_buf_full : hs_b.obf_n;
        hs_val[bph_pkg::PC_IRQ_OUT_A] = hs_a.irq_out;
        hs_val[bph_pkg::PC_IBF_A] = hs_a.in_buf_full;
        hs_val[bph_pkg::PC_OBF_A] = hs_a.obf_n;
        ie_vec = 8'h00;
        ie_vec[bph_pkg::PC_HS_B] = st_q.group_b_irq_enable;
        ie_vec[bph_pkg::PC_LOAD_A] = st_q.group_a_in_irq_enable;
        ie_vec[bph_pkg::PC_ACK_A] = st_q.group_a_out_irq_enable;
        io_out = ~(hs_out | hs_in) & {{4{!st_q.pcu_in}}, {4{!st_q.pcl_in}}};
        wr_mask = io_out & {{4{!a_hs}}, {4{!st_q.b_mode}}};
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pc
            assign pc_out[gi] = hs_out[gi] ? hs_val[gi] : st_q.pc_q[gi];
            assign pc_oe[gi] = hs_out[gi] | io_out[gi];
            assign pc_rd[gi] = hs_in[gi] ? ie_vec[gi] :
                               (pc_oe[gi] ? pc_out[gi] : pc_in[gi]);
        end
    endgenerate

    // ************************************************************
    // Data ports
    // ************************************************************
    logic [7:0] pa_rd;
    logic [7:0] pb_rd;

    assign pa_out = st_q.pa_q;
    assign pa_oe = {8{a_bidir ? hs_a.drive_en : !st_q.pa_in_dir}};
    assign pb_out = st_q.pb_q;
    assign pb_oe = {8{!st_q.pb_in_dir}};
    assign pa_rd = a_in_hs ? hs_a.latch : (st_q.pa_in_dir ? pa_in : st_q.pa_q);
    assign pb_rd = b_in_hs ? hs_b.latch : (st_q.pb_in_dir ? pb_in : st_q.pb_q);

    // ************************************************************
    // Group engines
    // ************************************************************
    logic frc_a;
    logic frc_b;
    bph_pkg::bph_frc_t frc_sel_a;
    bph_pkg::bph_frc_t frc_sel_b;

    always_comb begin
        frc_a = 1'b0;
        frc_b = 1'b0;
        frc_sel_a = bph_pkg::BPH_FRC_IRQ_OUT;
        frc_sel_b = bph_pkg::BPH_FRC_IRQ_OUT;
        if (bsr_wr && hs_out[bsr_bit]) begin
            case (bsr_bit)
                3'(bph_pkg::PC_IRQ_OUT_B): begin
                    frc_b = 1'b1;
                end
                3'(bph_pkg::PC_FULL_B): begin
                    frc_b = 1'b1;
                    frc_sel_b = st_q.pb_in_dir ? bph_pkg::BPH_FRC_IBF : bph_pkg::BPH_FRC_OBF;
                end
                3'(bph_pkg::PC_IRQ_OUT_A): begin
                    frc_a = 1'b1;
                end
                3'(bph_pkg::PC_IBF_A): begin
                    frc_a = 1'b1;
                    frc_sel_a = bph_pkg::BPH_FRC_IBF;
                end
                3'(bph_pkg::PC_OBF_A): begin
                    frc_a = 1'b1;
                    frc_sel_a = bph_pkg::BPH_FRC_OBF;
                end
                default: begin
                    frc_a = 1'b0;
                end
            endcase
        end
    end

    assign hs_a.en_in = a_in_hs;
    assign hs_a.en_out = a_out_hs;
    assign hs_a.clr = mode_wr;
    assign hs_a.stb_n = pc_in[bph_pkg::PC_LOAD_A];
    assign hs_a.ack_n = pc_in[bph_pkg::PC_ACK_A];
    assign hs_a.pins = pa_in;
    assign hs_a.rd_start = setup && !pwrite && sel_a;
    assign hs_a.rd_done = access && !pwrite && sel_a;
    assign hs_a.wr_start = setup && pwrite && sel_a;
    assign hs_a.wr_done = access && pwrite && sel_a;
    assign hs_a.ie_in = st_q.group_a_in_irq_enable;
    assign hs_a.ie_out = st_q.group_a_out_irq_enable;
    assign hs_a.frc_we = frc_a;
    assign hs_a.frc_sel = frc_sel_a;
    assign hs_a.frc_val = bsr_val;

    assign hs_b.en_in = b_in_hs;
    assign hs_b.en_out = b_out_hs;
    assign hs_b.clr = mode_wr;
    assign hs_b.stb_n = pc_in[bph_pkg::PC_HS_B];
    assign hs_b.ack_n = pc_in[bph_pkg::PC_HS_B];
    assign hs_b.pins = pb_in;
    assign hs_b.rd_start = setup && !pwrite && sel_b;
    assign hs_b.rd_done = access && !pwrite && sel_b;
    assign hs_b.wr_start = setup && pwrite && sel_b;
    assign hs_b.wr_done = access && pwrite && sel_b;
    assign hs_b.ie_in = st_q.group_b_irq_enable;
    assign hs_b.ie_out = st_q.group_b_irq_enable;
    assign hs_b.frc_we = frc_b;
    assign hs_b.frc_sel = frc_sel_b;
    assign hs_b.frc_val = bsr_val;

    bph_hs_group u_grp_a (
        .mclk (mclk),
        .rst  (rst),
        .hs   (hs_a)
    );

    bph_hs_group u_grp_b (
        .mclk (mclk),
        .rst  (rst),
        .hs   (hs_b)
    );

    // ************************************************************
    // Register state
    // ************************************************************
    always_comb begin
        st_d = st_q;
        if (setup && !pwrite) begin
            case (ofs)
                bph_pkg::OFS_PORT_A: begin
                    st_d.rdata = pa_rd;
                end
                bph_pkg::OFS_PORT_B: begin
                    st_d.rdata = pb_rd;
                end
                bph_pkg::OFS_PORT_C: begin
                    st_d.rdata = pc_rd;
                end
                default: begin
                    st_d.rdata = 8'h00;
                end
            endcase
            if (!addr_ok) begin
                st_d.rdata = 8'h00;
            end
        end
        if (access && pwrite && addr_ok) begin
            case (ofs)
                bph_pkg::OFS_PORT_A: begin
                    st_d.pa_q = pwdata[7:0];
                end
                bph_pkg::OFS_PORT_B: begin
                    st_d.pb_q = pwdata[7:0];
                end
                bph_pkg::OFS_PORT_C: begin
                    st_d.pc_q = (st_q.pc_q & ~wr_mask) | (pwdata[7:0] & wr_mask);
                end
                default: begin
                    st_d.rdata = st_q.rdata;
                end
            endcase
        end
        if (mode_wr) begin
            st_d = ST_RST;
            st_d.rdata = st_q.rdata;
            st_d.a_mode = pwdata[bph_pkg::CW_A_MODE_HI] ? bph_pkg::BPH_MODE_BIDIR :
                          (pwdata[bph_pkg::CW_A_MODE_LO] ? bph_pkg::BPH_MODE_STROBED :
                           bph_pkg::BPH_MODE_BASIC);
            st_d.pa_in_dir = pwdata[bph_pkg::CW_PA_IN];
            st_d.pcu_in = pwdata[bph_pkg::CW_PCU_IN];
            st_d.b_mode = pwdata[bph_pkg::CW_B_MODE];
            st_d.pb_in_dir = pwdata[bph_pkg::CW_PB_IN];
            st_d.pcl_in = pwdata[bph_pkg::CW_PCL_IN];
        end
        if (bsr_wr) begin
            if (hs_in[bsr_bit]) begin
                case (bsr_bit)
                    3'(bph_pkg::PC_HS_B): begin
                        st_d.group_b_irq_enable = bsr_val;
                    end
                    3'(bph_pkg::PC_LOAD_A): begin
                        st_d.group_a_in_irq_enable = bsr_val;
                    end
                    3'(bph_pkg::PC_ACK_A): begin
                        st_d.group_a_out_irq_enable = bsr_val;
                    end
                    default: begin
                        st_d.pc_q = st_q.pc_q;
                    end
                endcase
            end else if (io_out[bsr_bit]) begin
                st_d.pc_q[bsr_bit] = bsr_val;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

endmodule

// >>> tb/bph_props.sv
// Checker for the APB side and the group A handshake
`timescale 1ns/1ns
module bph_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Pins
    input wire logic [7:0]  pa_oe,
    input wire logic [7:0]  pc_in,
    input wire logic [7:0]  pc_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [1:0] m_q;
    wire        acc = psel && penable;
    wire        wr  = acc && pwrite;
    wire        bd  = m_q[1];
    // Tracks the group A mode so the handshake checks apply only in bidir
    always_ff @(posedge mclk)
        if (rst) m_q <= 2'h0;
        else if (wr && paddr == 12'h00C && pwdata[7]) m_q <= pwdata[6:5];
    ready_hi_a: assert property (acc |-> pready)
        else $error("pready low");
    bad_addr_a: assert property (acc && paddr > 12'h00C |-> pslverr)
        else $error("no slave error");
    rd_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read high bits");
    drive_ack_a: assert property (bd |-> pa_oe == {8{!pc_in[6]}})
        else $error("port A drive");
    obf_set_a: assert property (bd && wr && paddr == 12'h000 |=> !pc_out[7])
        else $error("out full not set");
    obf_clr_a: assert property (bd && !pc_in[6] && !wr |=> pc_out[7])
        else $error("out full not cleared");
    ibf_set_a: assert property (bd && !pc_in[4] && !wr |=> pc_out[5])
        else $error("in full not set");
    ibf_clr_a: assert property (bd && acc && !pwrite && paddr == 12'h000 && pc_in[4]
        |=> !pc_out[5])
        else $error("in full not cleared");
    mode_clr_a: assert property (wr && paddr == 12'h00C && pwdata[7]
        |=> !pc_out[5] && !pc_out[3])
        else $error("flags kept");
endmodule
bind bph_port_ctrl bph_props bph_props_i (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .pa_oe(pa_oe), .pc_in(pc_in), .pc_out(pc_out));

// >>> tb/bph_periph.sv
// Peripheral on the group A bidirectional port
`timescale 1ns/1ns
module bph_periph (
    // Clock
    input wire logic        mclk,
    // Port A lines
    input wire logic [7:0]  pa_out,
    input wire logic [7:0]  pa_oe,
    output logic [7:0]      pa_in,
    // Handshake
    output logic            load_n,
    output logic            ack_n
);
    logic [7:0] d_q = 8'h00;
    logic       drv = 1'b0;
    initial load_n = 1'b1;
    initial ack_n = 1'b1;
    // Released bus shows a changed level, never the last byte
    assign pa_in = pa_oe[0] ? pa_out : (drv ? d_q : ~d_q);
    task automatic send(input logic [7:0] b);
        @(posedge mclk);
        d_q <= b;
        drv <= 1'b1;
        load_n <= 1'b0;
        @(posedge mclk);
        load_n <= 1'b1;
        @(posedge mclk);
        drv <= 1'b0;
    endtask
    task automatic take(output logic [7:0] b);
        @(posedge mclk);
        ack_n <= 1'b0;
        repeat (2) @(posedge mclk);
        b = pa_in;
        ack_n <= 1'b1;
    endtask
endmodule

// >>> tb/tb_top.sv
// Bench for the port controller in bidirectional mode
`timescale 1ns/1ns
module tb_top;
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, load_n, ack_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  pa_in, pa_out, pa_oe, pb_out, pb_oe, pc_in, pc_out, pc_oe, rd;
    int          bad_count = 0, total_checks = 0, cyc = 0;
    assign pc_in = (pc_oe & pc_out) | (~pc_oe & {1'b1, ack_n, 1'b1, load_n, 4'hF});
    bph_port_ctrl bph_port_ctrl_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(8'h00),
        .pb_out(pb_out), .pb_oe(pb_oe), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe));
    bph_periph bph_periph_i (.mclk(mclk), .pa_out(pa_out), .pa_oe(pa_oe), .pa_in(pa_in),
        .load_n(load_n), .ack_n(ack_n));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic s_reset();
        apb(1'b0, 12'h008, 8'h00);
        chk("pc_rd", rd, 8'hFF);
        chk("pa_oe", pa_oe, 8'h00);
        chk("pb_oe", pb_oe, 8'h00);
        apb(1'b1, 12'h00C, 8'h0F);
        chk("bsr_in", pc_out, 8'h00);
        chk("pc_oe_in", pc_oe, 8'h00);
        apb(1'b0, 12'h010, 8'h00);
        chk("bad_rd", rd, 8'h00);
    endtask
    task automatic s_input();
        apb(1'b1, 12'h00C, 8'hC0);
        apb(1'b1, 12'h00C, 8'h09);
        bph_periph_i.send(8'h3C);
        @(posedge mclk);
        chk("in_hs", pc_out & 8'hA8, 8'hA8);
        chk("pc_oe", pc_oe, 8'hAF);
        apb(1'b0, 12'h000, 8'h00);
        chk("pa_rd", rd, 8'h3C);
        chk("rd_hs", pc_out & 8'hA8, 8'h80);
        apb(1'b0, 12'h008, 8'h00);
        chk("pc_in_en", rd, 8'h90);
    endtask
    task automatic s_output();
        apb(1'b1, 12'h00C, 8'h0D);
        apb(1'b1, 12'h000, 8'h5A);
        chk("out_hs", pc_out & 8'hA8, 8'h00);
        chk("pa_off", pa_oe, 8'h00);
        bph_periph_i.take(rd);
        chk("pa_data", rd, 8'h5A);
        repeat (2) @(posedge mclk);
        chk("out_irq", pc_out & 8'hA8, 8'h88);
        apb(1'b0, 12'h008, 8'h00);
        chk("pc_both", rd, 8'hD8);
    endtask
    task automatic s_direct();
        apb(1'b1, 12'h008, 8'hFF);
        apb(1'b0, 12'h008, 8'h00);
        chk("pc_wr", rd, 8'hDF);
        apb(1'b1, 12'h00C, 8'h06);
        apb(1'b0, 12'h008, 8'h00);
        chk("pc_bsr", rd, 8'hD7);
        apb(1'b1, 12'h00C, 8'hC0);
        apb(1'b0, 12'h008, 8'h00);
        chk("pc_mode", rd, 8'h80);
    endtask
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        s_reset();
        s_input();
        s_output();
        s_direct();
        report_and_stop();
    end
endmodule
